// [inc/amp2_pkg.sv]
// shared constants for the second amplifier control registers
package amp2_pkg;
   // register byte addresses (word aligned)
   localparam logic [7:0] STATUS_ADDR = 8'h00;
   localparam logic [7:0] PATH_ADDR   = 8'h04;
   localparam logic [7:0] GAIN_ADDR   = 8'h08;
   localparam logic [7:0] DECODE_ADDR = 8'h0C;
   // path control fields
   localparam int PATH_ENABLE_BIT  = 0;
   localparam int PATH_OUT_EN_BIT  = 1;
   localparam int PATH_NEG_PIN_BIT = 2;
   localparam int PATH_POS_PIN_BIT = 3;
   localparam int PATH_REF_LSB     = 4;
   localparam int PATH_FEEDBK_BIT  = 6;
   localparam int PATH_COMP_BIT    = 7;
   // gain control fields and status bit
   localparam int GAIN_CODE_LSB    = 0;
   localparam int GAIN_EN_BIT      = 3;
   localparam int GAIN_POS_RT_BIT  = 6;
   localparam int GAIN_NEG_RT_BIT  = 7;
   localparam int STATUS_BIT       = 7;
   // reset values and gain writable bit mask
   localparam logic [7:0] PATH_RESET  = 8'h0C;
   localparam logic [7:0] GAIN_RESET  = 8'h00;
   localparam logic [7:0] GAIN_IMPL   = 8'hCF;
   // reference selection codes
   localparam logic [1:0] REF_NONE = 2'h0;
   localparam logic [1:0] REF_HIGH = 2'h1;
   localparam logic [1:0] REF_MID  = 2'h2;
   localparam logic [1:0] REF_LOW  = 2'h3;
   // gain step per code value
   localparam logic [5:0] GAIN_STEP = 6'h08;
   localparam logic [5:0] GAIN_UNIT = 6'h01;
   // ahb encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage

// [verilog/amp2_gain_decode.sv]
// gain code to gain value decoder
`timescale 1ns/10ps
module amp2_gain_decode (
   input  wire logic [2:0] gain_code,
   output logic      [5:0] gain_value
);
   always_comb begin
      if (gain_code == 3'h0) begin
         gain_value = amp2_pkg::GAIN_UNIT;
      end else begin
         gain_value = 6'(gain_code * amp2_pkg::GAIN_STEP);
      end
   end
endmodule // amp2_gain_decode

// [verilog/amp2_path_gain_control.sv]
// register bank and switch controls for the second amplifier
//
// Operation
// - amplifier disabled forces gain enable and feedback bits to zero
// - feedback bit holds one only while amplifier is enabled
// - setting positive pin select clears amp1 positive route and reference field
// - setting negative pin select clears amp1 negative route
// - reference field: 00 none, 01 high, 10 mid, 11 low
// - gain code 000 gives 1, else eight times the code
// - gain enable bit turns programmable gain on or off
// - output enable bit drives output enable switch
// - amplifier enable bit powers the amplifier
// - negative pin select connects external inverting pin
// - positive pin select connects external noninverting pin
// - amp1 negative route closes amp1 output to inverting input path
// - feedback bit closes output to inverting input path
// - read-only status bit shows digitised amplifier output
`timescale 1ns/10ps
module amp2_path_gain_control (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        amp2_output_status,
   output logic             amp2_enable,
   output logic             amp2_output_enable,
   output logic             amp2_neg_pin_select,
   output logic             amp2_pos_pin_select,
   output logic             ref_high_sw,
   output logic             ref_mid_sw,
   output logic             ref_low_sw,
   output logic             amp2_feedback_route,
   output logic             amp2_to_comparator_route,
   output logic             amp1_to_amp2_pos_route,
   output logic             amp1_to_amp2_neg_route,
   output logic             gain_stage_enable,
   output logic      [2:0]  gain_code,
   output logic      [5:0]  gain_value
);
   logic [7:0] path_r;
   logic [7:0] path_nxt;
   logic [7:0] gain_r;
   logic [7:0] gain_nxt;
   logic       wr_pend_r;
   logic [7:0] wr_addr_r;
   logic       status_r;
   logic [5:0] gain_dec;
   logic       req;

   // address phase accepted when selected, active and bus ready
   assign req = hsel && hready && (htrans == amp2_pkg::HTRANS_NONSEQ ||
                                   htrans == amp2_pkg::HTRANS_SEQ);

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else if (hready) begin
         wr_pend_r <= req && hwrite;
         wr_addr_r <= haddr;
      end
   end

   // the slave never stalls, responses are always okay
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         status_r <= 1'b0;
      end else begin
         status_r <= amp2_output_status;
      end
   end

   // next register values: write first, then hardware clears
   always_comb begin
      path_nxt = path_r;
      gain_nxt = gain_r;
      if (wr_pend_r && wr_addr_r == amp2_pkg::PATH_ADDR) begin
         path_nxt = hwdata[7:0];
      end
      if (wr_pend_r && wr_addr_r == amp2_pkg::GAIN_ADDR) begin
         gain_nxt = hwdata[7:0] & amp2_pkg::GAIN_IMPL;
      end
      if (path_nxt[amp2_pkg::PATH_POS_PIN_BIT]) begin
         path_nxt[amp2_pkg::PATH_REF_LSB +: 2]   = amp2_pkg::REF_NONE;
         gain_nxt[amp2_pkg::GAIN_POS_RT_BIT]     = 1'b0;
      end
      if (path_nxt[amp2_pkg::PATH_NEG_PIN_BIT]) begin
         gain_nxt[amp2_pkg::GAIN_NEG_RT_BIT] = 1'b0;
      end
      if (!path_nxt[amp2_pkg::PATH_ENABLE_BIT]) begin
         path_nxt[amp2_pkg::PATH_FEEDBK_BIT] = 1'b0;
         gain_nxt[amp2_pkg::GAIN_EN_BIT]     = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         path_r <= amp2_pkg::PATH_RESET;
      end else begin
         path_r <= path_nxt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         gain_r <= amp2_pkg::GAIN_RESET;
      end else begin
         gain_r <= gain_nxt;
      end
   end

   // read data registered in the address phase, so stands in the data phase
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         hrdata <= 32'h0000_0000;
      end else if (req && !hwrite) begin
         case (haddr)
            amp2_pkg::STATUS_ADDR: hrdata <= {24'h00_0000, status_r, 7'h00};
            amp2_pkg::PATH_ADDR:   hrdata <= {24'h00_0000, path_nxt};
            amp2_pkg::GAIN_ADDR:   hrdata <= {24'h00_0000, gain_nxt};
            amp2_pkg::DECODE_ADDR: hrdata <= {26'h000_0000, gain_dec};
            default:               hrdata <= 32'h0000_0000;
         endcase
      end
   end

   amp2_gain_decode u_gain_decode (
      .gain_code  (gain_nxt[amp2_pkg::GAIN_CODE_LSB +: 3]),
      .gain_value (gain_dec)
   );

   // switch controls follow the register next values, so they change with the register
   // switch outputs
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         amp2_enable              <= amp2_pkg::PATH_RESET[amp2_pkg::PATH_ENABLE_BIT];
         amp2_output_enable       <= amp2_pkg::PATH_RESET[amp2_pkg::PATH_OUT_EN_BIT];
         amp2_neg_pin_select      <= amp2_pkg::PATH_RESET[amp2_pkg::PATH_NEG_PIN_BIT];
         amp2_pos_pin_select      <= amp2_pkg::PATH_RESET[amp2_pkg::PATH_POS_PIN_BIT];
         amp2_feedback_route      <= 1'b0;
         amp2_to_comparator_route <= 1'b0;
      end else begin
         amp2_enable              <= path_nxt[amp2_pkg::PATH_ENABLE_BIT];
         amp2_output_enable       <= path_nxt[amp2_pkg::PATH_OUT_EN_BIT];
         amp2_neg_pin_select      <= path_nxt[amp2_pkg::PATH_NEG_PIN_BIT];
         amp2_pos_pin_select      <= path_nxt[amp2_pkg::PATH_POS_PIN_BIT];
         amp2_feedback_route      <= path_nxt[amp2_pkg::PATH_FEEDBK_BIT];
         amp2_to_comparator_route <= path_nxt[amp2_pkg::PATH_COMP_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ref_high_sw <= 1'b0;
         ref_mid_sw  <= 1'b0;
         ref_low_sw  <= 1'b0;
      end else begin
         ref_high_sw <= path_nxt[amp2_pkg::PATH_REF_LSB +: 2] == amp2_pkg::REF_HIGH;
         ref_mid_sw  <= path_nxt[amp2_pkg::PATH_REF_LSB +: 2] == amp2_pkg::REF_MID;
         ref_low_sw  <= path_nxt[amp2_pkg::PATH_REF_LSB +: 2] == amp2_pkg::REF_LOW;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         amp1_to_amp2_pos_route <= 1'b0;
         amp1_to_amp2_neg_route <= 1'b0;
         gain_stage_enable      <= 1'b0;
         gain_code              <= 3'h0;
         gain_value             <= amp2_pkg::GAIN_UNIT;
      end else begin
         amp1_to_amp2_pos_route <= gain_nxt[amp2_pkg::GAIN_POS_RT_BIT];
         amp1_to_amp2_neg_route <= gain_nxt[amp2_pkg::GAIN_NEG_RT_BIT];
         gain_stage_enable      <= gain_nxt[amp2_pkg::GAIN_EN_BIT];
         gain_code              <= gain_nxt[amp2_pkg::GAIN_CODE_LSB +: 3];
         gain_value             <= gain_dec;
      end
   end
endmodule // amp2_path_gain_control

// [testbench/amp2_path_gain_control_assertions.sv]
// assertion checker for the second amplifier control block
`timescale 1ns/10ps
module amp2_ctl_checker (
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        amp2_enable,
   input wire logic        amp2_output_enable,
   input wire logic        amp2_neg_pin_select,
   input wire logic        amp2_pos_pin_select,
   input wire logic        ref_high_sw,
   input wire logic        ref_mid_sw,
   input wire logic        ref_low_sw,
   input wire logic        amp2_feedback_route,
   input wire logic        amp1_to_amp2_pos_route,
   input wire logic        amp1_to_amp2_neg_route,
   input wire logic        gain_stage_enable,
   input wire logic [2:0]  gain_code,
   input wire logic [5:0]  gain_value
);
   wire       pos_any  = amp1_to_amp2_pos_route | ref_high_sw | ref_mid_sw | ref_low_sw;
   wire [5:0] gain_exp = (gain_code == 3'h0) ? 6'h01 : {gain_code, 3'h0};
   wire [1:0] wd_lo    = hwdata[1:0];
   // pos pin select in the same write forces the reference field to none
   wire [2:0] ref_exp  = hwdata[3] ? 3'h0 :
                         {hwdata[5] & hwdata[4], hwdata[5] & !hwdata[4], !hwdata[5] & hwdata[4]};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence path_wr;
      hsel && hready && htrans[1] && hwrite && haddr == amp2_pkg::PATH_ADDR;
   endsequence
   // data phase follows, so the level lands one edge later
   property p_lands;
      path_wr ##1 1'b1 |=> {amp2_output_enable, amp2_enable} == $past(wd_lo);
   endproperty
   property p_ref_lands;
      path_wr ##1 1'b1 |=> {ref_low_sw, ref_mid_sw, ref_high_sw} == $past(ref_exp);
   endproperty
   chk_fb_needs_en: assert property (amp2_feedback_route |-> amp2_enable)
      else $error("feedback on while amp off");
   chk_gain_needs_en: assert property (gain_stage_enable |-> amp2_enable)
      else $error("gain on while amp off");
   chk_pos_clears: assert property (amp2_pos_pin_select |-> !pos_any)
      else $error("pos pin select left a route");
   chk_neg_clears: assert property (amp2_neg_pin_select |-> !amp1_to_amp2_neg_route)
      else $error("neg pin select left a route");
   chk_ref_onehot: assert property ($onehot0({ref_high_sw, ref_mid_sw, ref_low_sw}))
      else $error("reference switches overlap");
   chk_gain_map: assert property (gain_value == gain_exp)
      else $error("gain value wrong");
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   chk_write_lands: assert property (p_lands)
      else $error("path write did not land");
   chk_ref_lands: assert property (p_ref_lands)
      else $error("reference decode did not follow write");
endmodule // amp2_ctl_checker

bind amp2_path_gain_control amp2_ctl_checker u_chk (.*);

// [testbench/tb.sv]
// self-checking bench for the second amplifier control block
`timescale 1ns/10ps
module tb;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic        st = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [7:0]  haddr = 8'h00;
   logic [31:0] hwdata = 32'h0;
   logic        hready;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic [20:0] sw;
   logic [7:0]  p = 8'h0C, g = 8'h00, a;
   logic [31:0] rd, d;
   integer      error_cnt = 0, total_checks = 0, seed = 36, i;
   always #2 clk_sys = ~clk_sys;
   assign hready = hreadyout;
   amp2_path_gain_control u_dut (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .amp2_output_status(st),
      .amp2_enable(sw[20]), .amp2_output_enable(sw[19]), .amp2_neg_pin_select(sw[18]),
      .amp2_pos_pin_select(sw[17]), .ref_high_sw(sw[16]), .ref_mid_sw(sw[15]),
      .ref_low_sw(sw[14]), .amp2_feedback_route(sw[13]), .amp2_to_comparator_route(sw[12]),
      .amp1_to_amp2_pos_route(sw[11]), .amp1_to_amp2_neg_route(sw[10]),
      .gain_stage_enable(sw[9]), .gain_code(sw[8:6]), .gain_value(sw[5:0]));
   function automatic logic [5:0] gv(input logic [2:0] c);
      return (c == 3'h0) ? 6'h01 : 6'(int'(c) * 8);
   endfunction
   function automatic logic [20:0] swx();
      return {p[0], p[1], p[2], p[3], p[5:4] == 2'h1, p[5:4] == 2'h2, p[5:4] == 2'h3,
              p[6], p[7], g[6], g[7], g[3], g[2:0], gv(g[2:0])};
   endfunction
   function automatic logic [31:0] rdx(input logic [7:0] ad);
      case (ad)
         amp2_pkg::STATUS_ADDR: return {24'h0, st, 7'h0};
         amp2_pkg::PATH_ADDR: return {24'h0, p};
         amp2_pkg::GAIN_ADDR: return {24'h0, g};
         amp2_pkg::DECODE_ADDR: return {26'h0, gv(g[2:0])};
         default: return 32'h0;
      endcase
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // bounded wait for hready, a hang ends the run
   task automatic wt();
      integer k;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (hreadyout !== 1'b1 && k < 16);
      if (hreadyout !== 1'b1) begin
         error_cnt++;
         print_verdict();
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= ad;
      htrans <= amp2_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      wt();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wt();
      rd = hrdata;
   endtask
   // one write, model update, read back and switch compare
   task automatic step(input logic [7:0] ad, input logic [31:0] wd);
      st <= wd[31];
      ahb(1'b1, ad, wd);
      if (ad == amp2_pkg::PATH_ADDR) p = wd[7:0];
      if (ad == amp2_pkg::GAIN_ADDR) g = wd[7:0] & 8'hCF;
      if (p[3]) {p[5:4], g[6]} = 3'h0;
      if (p[2]) g[7] = 1'b0;
      if (!p[0]) {p[6], g[3]} = 2'h0;
      ahb(1'b0, ad, 32'h0);
      cmp(rd, rdx(ad));
      cmp(32'(sw), 32'(swx()));
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      for (i = 0; i < 5; i++) begin
         a = 8'(i * 4);
         ahb(1'b0, a, 32'h0);
         cmp(rd, rdx(a));
      end
      cmp(32'(sw), 32'(swx()));
      $display("test reset_values done");
      // software order: pin selects off first, mid reference and gain set next, comparator route after that, amplifier disabled last
      step(amp2_pkg::PATH_ADDR, 32'h0000_0001);
      step(amp2_pkg::PATH_ADDR, 32'h0000_0021);
      step(amp2_pkg::GAIN_ADDR, 32'h0000_008D);
      step(amp2_pkg::PATH_ADDR, 32'h0000_00E1);
      step(amp2_pkg::PATH_ADDR, 32'h0000_00E0);
      $display("test software_order done");
      for (i = 0; i < 600; i++) begin
         a = 8'(($unsigned($random(seed)) % 5) * 4);
         d = $random(seed);
         step(a, d);
      end
      $display("test random_traffic done");
      print_verdict();
   end
endmodule // tb
